/* include/ssi_defines.svh */
`ifndef SSI_DEFINES_SVH
`define SSI_DEFINES_SVH
// Register indexes; the byte address on the bus is four times the index.
`define SSI_IDX_FLAGS 8'h0c
`define SSI_IDX_BUF 8'h13
`define SSI_IDX_CTRL 8'h14
`define SSI_IDX_ENABLES 8'h8c
`define SSI_IDX_STATUS 8'h94
`define SSI_IDX_DIR 8'h86
`define SSI_IDX_OWNADDR 8'h93
// Reset values.
`define SSI_RST_CTRL 8'h00
`define SSI_RST_STATUS 8'h00
`define SSI_RST_FLAGS 8'h00
`define SSI_RST_ENABLES 8'h00
`define SSI_RST_DIR 8'hff
`define SSI_RST_OWNADDR 8'h00
// Control register fields.
`define SSI_CTRL_COLL 7
`define SSI_CTRL_OV 6
`define SSI_CTRL_EN 5
`define SSI_CTRL_CKP 4
// Status register fields.
`define SSI_ST_DA 5
`define SSI_ST_P 4
`define SSI_ST_S 3
`define SSI_ST_RW 2
`define SSI_ST_ADDR_UPD 1
`define SSI_ST_FULL 0
// Interrupt flag position and direction bits of the bus pins.
`define SSI_FLAG_SERIAL 3
`define SSI_DIR_SDA 1
`define SSI_DIR_DOUT 2
`define SSI_DIR_SCL 4
// Mode codes.
`define SSI_MODE_SPI_CS 4'h4
`define SSI_MODE_I2C7 4'h6
`define SSI_MODE_I2C10 4'h7
`define SSI_MODE_FWM 4'hb
`define SSI_MODE_I2C7_SP 4'he
`define SSI_MODE_I2C10_SP 4'hf
// Ten-bit address header pattern.
`define SSI_TEN_HDR 5'h1e
`endif

/* include/ssi_pkg.sv */
package ssi_pkg;
	// Phase of the slave engine, one-hot.
	typedef enum logic [3:0] {
		ph_idle = 4'b0001,
		ph_addr = 4'b0010,
		ph_rx = 4'b0100,
		ph_tx = 4'b1000
	} ssi_phase_e;
endpackage : ssi_pkg

/* hw/ssi_i2c_slave.sv */
`timescale 1ns/100ps
`include "ssi_defines.svh"
module ssi_i2c_slave (
	input wire logic clk,
	input wire logic reset,
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic irq,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic cs_pin,
	output logic [7:0] port_dir
);
	// Synchroniser stages and the previous sampled level of each bus pin.
	logic scl_s1_r, scl_s2_r, scl_q_r;
	logic sda_s1_r, sda_s2_r, sda_q_r;
	logic cs_s1_r, cs_s2_r;
	// Software visible registers.
	logic [7:0] ctrl_r, status_r, flags_r, enables_r, dir_r, own_addr_r, buf_r;
	// Engine state; the shift register is internal only.
	ssi_pkg::ssi_phase_e phase_r;
	logic [3:0] cnt_r;
	logic [7:0] shift_register;
	logic ack_drv_r, stage2_r, matched10_r, hit_r, nack_r;
	// Bus slave state.
	logic ack_r;
	logic [31:0] readdata_r;

	// Two flip-flops per pin, then a third on clock and data only for edge finding.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_q_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_q_r <= 1'b1;
			cs_s1_r <= 1'b1;
			cs_s2_r <= 1'b1;
		end else begin
			scl_s1_r <= scl_in;
			scl_s2_r <= scl_s1_r;
			scl_q_r <= scl_s2_r;
			sda_s1_r <= sda_in;
			sda_s2_r <= sda_s1_r;
			sda_q_r <= sda_s2_r;
			cs_s1_r <= cs_pin;
			cs_s2_r <= cs_s1_r;
		end
	end

	// Edges of the clock line and bus conditions.
	wire scl_rise = scl_s2_r & ~scl_q_r;
	wire scl_fall = ~scl_s2_r & scl_q_r;
	wire start_det = scl_s2_r & scl_q_r & sda_q_r & ~sda_s2_r;
	wire stop_det = scl_s2_r & scl_q_r & ~sda_q_r & sda_s2_r;

	// Mode decode.
	wire [3:0] mode = ctrl_r[3:0];
	wire en = ctrl_r[`SSI_CTRL_EN];
	wire ckp = ctrl_r[`SSI_CTRL_CKP];
	wire is_i2c = (mode == `SSI_MODE_I2C7) | (mode == `SSI_MODE_I2C10) |
		(mode == `SSI_MODE_FWM) | (mode == `SSI_MODE_I2C7_SP) | (mode == `SSI_MODE_I2C10_SP);
	wire i2c_on = en & is_i2c;
	wire slave_on = i2c_on & (mode != `SSI_MODE_FWM);
	wire sp_irq_on = i2c_on & mode[3];
	wire ten = mode[0];
	wire spi_cs_hi = en & (mode == `SSI_MODE_SPI_CS) & cs_s2_r;
	wire buf_full = status_r[`SSI_ST_FULL];
	wire ov = ctrl_r[`SSI_CTRL_OV];

	// Avalon slave: one wait cycle, answer on the second edge.
	assign waitrequest = (read | write) & ~ack_r;
	wire rd_take = read & ack_r;
	wire wr_take = write & ack_r & byteenable[0];
	wire hit_flags = address == {`SSI_IDX_FLAGS, 2'b00};
	wire hit_buf = address == {`SSI_IDX_BUF, 2'b00};
	wire hit_ctrl = address == {`SSI_IDX_CTRL, 2'b00};
	wire hit_en = address == {`SSI_IDX_ENABLES, 2'b00};
	wire hit_st = address == {`SSI_IDX_STATUS, 2'b00};
	wire hit_dir = address == {`SSI_IDX_DIR, 2'b00};
	wire hit_oa = address == {`SSI_IDX_OWNADDR, 2'b00};

	// Address match: seven bit, or the two steps of ten bit addressing.
	logic match;
	always_comb begin
		if (!ten)
			match = shift_register[7:1] == own_addr_r[7:1];
		else if (stage2_r)
			match = shift_register == own_addr_r;
		else
			match = (shift_register[7:3] == `SSI_TEN_HDR) &
				(shift_register[7:1] == own_addr_r[7:1]) &
				(~shift_register[0] | matched10_r);
	end

	// Byte decision on the falling edge of the eighth clock pulse.
	wire fall8 = scl_fall & (cnt_r == 4'h8) &
		((phase_r == ssi_pkg::ph_addr) | (phase_r == ssi_pkg::ph_rx));
	wire fall9 = scl_fall & (cnt_r == 4'h9);
	wire accept = fall8 & ((phase_r == ssi_pkg::ph_rx) | match);
	wire load_ev = accept & ~buf_full & ~ov;
	wire ov_ev = accept & (buf_full | ov) & (phase_r == ssi_pkg::ph_rx);
	wire tx_load = wr_take & hit_buf & (phase_r == ssi_pkg::ph_tx) & (cnt_r == 4'h0);
	wire write_collision_flag_ev = wr_take & hit_buf & (phase_r == ssi_pkg::ph_tx) & (cnt_r != 4'h0);
	wire if_ev = (fall9 & hit_r) | ((start_det | stop_det) & sp_irq_on);

	// Slave engine: bit count, shifting, acknowledge and phase.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			phase_r <= ssi_pkg::ph_idle;
			cnt_r <= 4'h0;
			shift_register <= 8'h00;
			ack_drv_r <= 1'b0;
			stage2_r <= 1'b0;
			matched10_r <= 1'b0;
			hit_r <= 1'b0;
			nack_r <= 1'b0;
		end else if (!slave_on || spi_cs_hi) begin
			// Disabled, or chip-select high: all serial logic held cleared.
			phase_r <= ssi_pkg::ph_idle;
			cnt_r <= 4'h0;
			shift_register <= 8'h00;
			ack_drv_r <= 1'b0;
			stage2_r <= 1'b0;
			matched10_r <= 1'b0;
			hit_r <= 1'b0;
			nack_r <= 1'b0;
		end else if (stop_det) begin
			// Stop ends any transfer.
			phase_r <= ssi_pkg::ph_idle;
			ack_drv_r <= 1'b0;
			matched10_r <= 1'b0;
			hit_r <= 1'b0;
		end else if (start_det) begin
			// Start or repeated start: receive an address byte.
			phase_r <= ssi_pkg::ph_addr;
			cnt_r <= 4'h0;
			stage2_r <= 1'b0;
			ack_drv_r <= 1'b0;
			hit_r <= 1'b0;
		end else if (tx_load) begin
			// Buffer write while stretched loads the outgoing byte.
			shift_register <= writedata[7:0];
		end else if (scl_rise && phase_r != ssi_pkg::ph_idle) begin
			if (cnt_r < 4'h8) begin
				if (phase_r != ssi_pkg::ph_tx)
					shift_register <= {shift_register[6:0], sda_s2_r};
				cnt_r <= cnt_r + 4'h1;
			end else if (cnt_r == 4'h8) begin
				// Ninth pulse: a transmitter latches the master's answer.
				nack_r <= sda_s2_r;
				hit_r <= hit_r | (phase_r == ssi_pkg::ph_tx);
				cnt_r <= 4'h9;
			end
		end else if (scl_fall && phase_r != ssi_pkg::ph_idle) begin
			if (fall8) begin
				ack_drv_r <= load_ev;
				hit_r <= accept;
				if (!accept)
					phase_r <= ssi_pkg::ph_idle;
			end else if (fall9) begin
				ack_drv_r <= 1'b0;
				cnt_r <= 4'h0;
				hit_r <= 1'b0;
				case (phase_r)
					ssi_pkg::ph_addr: begin
						if (ten && !stage2_r && !shift_register[0])
							stage2_r <= 1'b1;
						else if (shift_register[0])
							phase_r <= ssi_pkg::ph_tx;
						else begin
							matched10_r <= ten;
							phase_r <= ssi_pkg::ph_rx;
						end
					end
					ssi_pkg::ph_rx: phase_r <= ssi_pkg::ph_rx;
					ssi_pkg::ph_tx: begin
						if (nack_r)
							phase_r <= ssi_pkg::ph_idle;
					end
					default: phase_r <= ssi_pkg::ph_idle;
				endcase
			end else if (phase_r == ssi_pkg::ph_tx && cnt_r != 4'h0 && cnt_r < 4'h9) begin
				// Next outgoing bit after each fall; ones behind it free the line for the ack.
				shift_register <= {shift_register[6:0], 1'b1};
			end
		end
	end

	// Control register: software fields plus collision, overflow, clock hold.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_r <= `SSI_RST_CTRL;
		end else begin
			if (wr_take && hit_ctrl)
				ctrl_r <= writedata[7:0];
			if (ov_ev)
				ctrl_r[`SSI_CTRL_OV] <= 1'b1;
			if (write_collision_flag_ev)
				ctrl_r[`SSI_CTRL_COLL] <= 1'b1;
			// A transmitter stretches the clock until software releases it.
			if (fall9 && ((phase_r == ssi_pkg::ph_addr && shift_register[0] &&
				(!ten || stage2_r || matched10_r)) ||
				(phase_r == ssi_pkg::ph_tx && !nack_r)))
				ctrl_r[`SSI_CTRL_CKP] <= 1'b0;
		end
	end

	// Status register: hardware bits, with edge and sample bits writable.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			status_r <= `SSI_RST_STATUS;
		end else begin
			if (wr_take && hit_st)
				status_r[7:6] <= writedata[7:6];
			if (!en) begin
				status_r[`SSI_ST_S] <= 1'b0;
				status_r[`SSI_ST_P] <= 1'b0;
			end else if (start_det) begin
				status_r[`SSI_ST_S] <= 1'b1;
				status_r[`SSI_ST_P] <= 1'b0;
			end else if (stop_det) begin
				status_r[`SSI_ST_S] <= 1'b0;
				status_r[`SSI_ST_P] <= 1'b1;
			end
			if (wr_take && hit_oa)
				status_r[`SSI_ST_ADDR_UPD] <= 1'b0;
			if (accept && phase_r == ssi_pkg::ph_addr) begin
				status_r[`SSI_ST_DA] <= 1'b0;
				status_r[`SSI_ST_RW] <= shift_register[0];
				if (ten && !matched10_r)
					status_r[`SSI_ST_ADDR_UPD] <= 1'b1;
			end else if (accept)
				status_r[`SSI_ST_DA] <= 1'b1;
			// Full clears on a buffer read; a new load wins.
			if (rd_take && hit_buf)
				status_r[`SSI_ST_FULL] <= 1'b0;
			if (load_ev)
				status_r[`SSI_ST_FULL] <= 1'b1;
		end
	end

	// Receive buffer: loaded from the shift register or by software.
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			buf_r <= 8'h00;
		else if (load_ev)
			buf_r <= shift_register;
		else if (wr_take && hit_buf && !write_collision_flag_ev)
			buf_r <= writedata[7:0];
	end

	// Own address, pin directions and interrupt enables.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			own_addr_r <= `SSI_RST_OWNADDR;
			dir_r <= `SSI_RST_DIR;
			enables_r <= `SSI_RST_ENABLES;
		end else begin
			if (wr_take && hit_oa)
				own_addr_r <= writedata[7:0];
			if (wr_take && hit_dir)
				dir_r <= writedata[7:0];
			if (wr_take && hit_en)
				enables_r <= writedata[7:0];
		end
	end

	// Interrupt flags: sticky, cleared by reading, an event wins the clear.
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			flags_r <= `SSI_RST_FLAGS;
		else if (if_ev)
			flags_r[`SSI_FLAG_SERIAL] <= 1'b1;
		else if (rd_take && hit_flags)
			flags_r <= 8'h00;
	end

	assign irq = |(flags_r & enables_r);

	// Direction readback: chip-select high shows data-out as input.
	wire [7:0] dir_view = dir_r | {5'h00, spi_cs_hi, 2'b00};
	assign port_dir = dir_view;

	// Read data captured in the wait cycle.
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (hit_flags)
			rd_mux = flags_r;
		else if (hit_buf)
			rd_mux = buf_r;
		else if (hit_ctrl)
			rd_mux = ctrl_r;
		else if (hit_en)
			rd_mux = enables_r;
		else if (hit_st)
			rd_mux = status_r;
		else if (hit_dir)
			rd_mux = dir_view;
		else if (hit_oa)
			rd_mux = own_addr_r;
	end

	// Bus acknowledge and read data.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ack_r <= 1'b0;
			readdata_r <= 32'h0000_0000;
		end else begin
			ack_r <= (read | write) & ~ack_r;
			if (read && !ack_r)
				readdata_r <= {24'h00_0000, rd_mux};
		end
	end

	assign readdata = readdata_r;

	// Open-drain pin drive, only with both directions set to input.
	wire pins_ok = i2c_on & dir_r[`SSI_DIR_SDA] & dir_r[`SSI_DIR_SCL];
	// Transmit data changes only after clock falls, so it never moves while the clock is high.
	wire sda_low = ack_drv_r | ((phase_r == ssi_pkg::ph_tx) & ~shift_register[7]);
	wire scl_low = (phase_r == ssi_pkg::ph_tx) & ~ckp & (cnt_r == 4'h0);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sda_oe_n <= 1'b1;
			scl_oe_n <= 1'b1;
		end else begin
			sda_oe_n <= ~(pins_ok & sda_low);
			scl_oe_n <= ~(pins_ok & scl_low);
		end
	end

	assign sda_out = 1'b0;
	assign scl_out = 1'b0;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	disabled_idle_a: assert property (!en |=> phase_r == ssi_pkg::ph_idle)
		else $error("engine not idle while disabled");
	cs_reset_a: assert property (spi_cs_hi |=> cnt_r == 4'h0 && !ack_drv_r)
		else $error("chip-select high did not clear serial logic");
	dir_readback_a: assert property (spi_cs_hi && read && hit_dir && !ack_r
		|=> readdata_r[`SSI_DIR_DOUT])
		else $error("data-out direction not read back set");
	start_irq_a: assert property (start_det && sp_irq_on |=> flags_r[`SSI_FLAG_SERIAL])
		else $error("start did not raise flag");
	pins_gated_a: assert property (!pins_ok |=> sda_oe_n && scl_oe_n)
		else $error("bus pin driven while not permitted");
	ack_load_a: assert property (load_ev |=> ack_drv_r && status_r[`SSI_ST_FULL]
		&& buf_r == $past(shift_register))
		else $error("accepted byte not acknowledged and buffered");
	full_noack_a: assert property (fall8 && (buf_full || ov) |=> !ack_drv_r
		&& buf_r == $past(buf_r))
		else $error("acknowledged with buffer full or overflow");
	buf_clear_a: assert property (rd_take && hit_buf && !load_ev
		|=> !status_r[`SSI_ST_FULL])
		else $error("buffer read did not clear full");
	ninth_irq_a: assert property (fall9 && hit_r |=> flags_r[`SSI_FLAG_SERIAL])
		else $error("flag not set at ninth falling edge");
	start_bits_a: assert property (start_det && en |=> status_r[`SSI_ST_S]
		&& !status_r[`SSI_ST_P])
		else $error("start bits wrong after start");
	bus_answer_a: assert property ((read || write) && !ack_r |=> !waitrequest [*1]
		##1 1'b1)
		else $error("bus answer not on second edge");
endmodule : ssi_i2c_slave

/* bench/ssi_i2c_master_model.sv */
`timescale 1ns/100ps
// Behavioural bus master; a released line floats high through the pull-up.
module ssi_i2c_master_model (
	input wire logic clk,
	input wire logic scl_wire,
	input wire logic sda_wire,
	output logic scl_rel,
	output logic sda_rel
);
	// The bus idles with both lines released and the clock standing high.
	initial begin
		scl_rel = 1'b1;
		sda_rel = 1'b1;
	end
	// Half of the 320 ns link period is four system clocks.
	task automatic half_bit();
		repeat (4) @(posedge clk);
	endtask : half_bit
	// Releases the clock and waits, bounded, while a slave stretches it low.
	task automatic rise();
		int n;
		n = 0;
		scl_rel <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (scl_wire !== 1'b1 && n < 400);
		// A clock held low past the bound ends the run as a mismatch.
		if (scl_wire !== 1'b1) begin
			tb_top.fails++;
			tb_top.end_of_test();
		end
		repeat (3) @(posedge clk);
	endtask : rise
	// Data falls while the clock is high, then the clock is pulled low.
	task automatic start_cond();
		sda_rel <= 1'b0;
		half_bit();
		scl_rel <= 1'b0;
		half_bit();
	endtask : start_cond
	// Data rises while the clock is high, leaving the bus idle.
	task automatic stop_cond();
		sda_rel <= 1'b0;
		half_bit();
		rise();
		sda_rel <= 1'b1;
		half_bit();
	endtask : stop_cond
	// Sends eight bits first bit highest, then samples the acknowledge late in the ninth pulse.
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_rel <= b[i];
			half_bit();
			rise();
			scl_rel <= 1'b0;
			// Data moves a clock after the fall, so no false start or stop is seen.
			@(posedge clk);
		end
		sda_rel <= 1'b1;
		half_bit();
		rise();
		ack = sda_wire;
		scl_rel <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : put_byte
	// Clocks eight bits in from the slave, sampled late in each high, then answers with nak.
	task automatic get_byte(input logic nak, output logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			half_bit();
			rise();
			b[i] = sda_wire;
			scl_rel <= 1'b0;
			@(posedge clk);
		end
		sda_rel <= nak;
		half_bit();
		rise();
		scl_rel <= 1'b0;
		@(posedge clk);
		sda_rel <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : get_byte
endmodule : ssi_i2c_master_model

/* bench/tb_top.sv */
`timescale 1ns/100ps
`include "ssi_defines.svh"
// Self-checking bench: register bus master, bus master model and scenario tasks.
module tb_top;
	logic clk = 1'b0;
	logic reset;
	logic [9:0] address;
	logic read;
	logic write;
	logic [3:0] byteenable;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic waitrequest;
	logic irq;
	logic scl_oe_n;
	logic sda_oe_n;
	logic cs_pin;
	logic [7:0] port_dir;
	logic scl_rel;
	logic sda_rel;
	logic scl_wire;
	logic sda_wire;
	int fails = 0;
	int checks_done = 0;
	// Open-drain wires: any party pulling low wins, else the pull-up holds them high.
	assign scl_wire = scl_rel & scl_oe_n;
	assign sda_wire = sda_rel & sda_oe_n;
	// The 25 MHz system clock.
	always #20 clk = ~clk;
	ssi_i2c_slave ssi_i2c_slave_inst (.clk(clk), .reset(reset), .address(address), .read(read),
		.write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .irq(irq), .scl_in(scl_wire), .scl_out(),
		.scl_oe_n(scl_oe_n), .sda_in(sda_wire), .sda_out(), .sda_oe_n(sda_oe_n),
		.cs_pin(cs_pin), .port_dir(port_dir));
	ssi_i2c_master_model ssi_i2c_master_model_inst (.clk(clk), .scl_wire(scl_wire),
		.sda_wire(sda_wire), .scl_rel(scl_rel), .sda_rel(sda_rel));
	// Prints the counts and the verdict, then stops the run.
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test
	// Compares a seen value with the expected one.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// One bus transfer, held until waitrequest is sampled low; a gap cycle follows.
	task automatic acc(input logic rd, input logic [7:0] idx, input logic [7:0] wd,
		output logic [7:0] rv);
		int n;
		n = 0;
		address <= {idx, 2'b00};
		read <= rd;
		write <= !rd;
		byteenable <= 4'hf;
		writedata <= {24'h000000, wd};
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			fails++;
			end_of_test();
		end
		rv = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask : acc
	// Register write.
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] v;
		acc(1'b0, idx, d, v);
	endtask : wr
	// Register read compared under a mask.
	task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] m,
		input logic [7:0] exp);
		logic [7:0] v;
		acc(1'b1, idx, 8'h00, v);
		check(what, {24'h000000, v & m}, {24'h000000, exp});
	endtask : rd_chk
	// Reset values of every register except own address and buffer, and an unmapped index that reads zero.
	task automatic reset_values();
		rd_chk("ctrl", `SSI_IDX_CTRL, 8'hff, `SSI_RST_CTRL);
		rd_chk("status", `SSI_IDX_STATUS, 8'hff, `SSI_RST_STATUS);
		rd_chk("flags", `SSI_IDX_FLAGS, 8'hff, `SSI_RST_FLAGS);
		rd_chk("enables", `SSI_IDX_ENABLES, 8'hff, `SSI_RST_ENABLES);
		rd_chk("direction", `SSI_IDX_DIR, 8'hff, `SSI_RST_DIR);
		rd_chk("unmapped", 8'h55, 8'hff, 8'h00);
		check("irq idle", irq, 1'b0);
	endtask : reset_values
	// Matched address, refusals while full and overflowed, recovery, then stop.
	task automatic addr_receive();
		logic ack;
		wr(`SSI_IDX_OWNADDR, 8'h50);
		wr(`SSI_IDX_ENABLES, 8'h08);
		wr(`SSI_IDX_CTRL, 8'h26);
		ssi_i2c_master_model_inst.start_cond();
		rd_chk("start seen", `SSI_IDX_STATUS, 8'h18, 8'h08);
		ssi_i2c_master_model_inst.put_byte(8'h50, ack);
		check("address ack", ack, 1'b0);
		check("irq raised", irq, 1'b1);
		rd_chk("flag set", `SSI_IDX_FLAGS, 8'h08, 8'h08);
		check("irq cleared", irq, 1'b0);
		rd_chk("buffer full", `SSI_IDX_STATUS, 8'h01, 8'h01);
		ssi_i2c_master_model_inst.put_byte(8'ha5, ack);
		check("nack full", ack, 1'b1);
		rd_chk("flag on nack", `SSI_IDX_FLAGS, 8'h08, 8'h08);
		rd_chk("overflow", `SSI_IDX_CTRL, 8'hff, 8'h66);
		rd_chk("buffer", `SSI_IDX_BUF, 8'hff, 8'h50);
		rd_chk("full cleared", `SSI_IDX_STATUS, 8'h01, 8'h00);
		ssi_i2c_master_model_inst.put_byte(8'h3c, ack);
		check("nack overflow", ack, 1'b1);
		rd_chk("no load", `SSI_IDX_STATUS, 8'h01, 8'h00);
		wr(`SSI_IDX_CTRL, 8'h26);
		rd_chk("overflow cleared", `SSI_IDX_CTRL, 8'hff, 8'h26);
		ssi_i2c_master_model_inst.put_byte(8'hc3, ack);
		check("data ack", ack, 1'b0);
		rd_chk("data buffered", `SSI_IDX_BUF, 8'hff, 8'hc3);
		ssi_i2c_master_model_inst.stop_cond();
		rd_chk("stop seen", `SSI_IDX_STATUS, 8'h18, 8'h10);
	endtask : addr_receive
	// A foreign address is refused and raises no flag.
	task automatic addr_mismatch();
		logic ack;
		rd_chk("flags drained", `SSI_IDX_FLAGS, 8'h08, 8'h08);
		ssi_i2c_master_model_inst.start_cond();
		ssi_i2c_master_model_inst.put_byte(8'h52, ack);
		check("mismatch nack", ack, 1'b1);
		ssi_i2c_master_model_inst.stop_cond();
		rd_chk("no flag", `SSI_IDX_FLAGS, 8'h08, 8'h00);
	endtask : addr_mismatch
	// Read from the slave: the clock is held until software loads a byte and sets the clock bit, sent highest bit first.
	task automatic slave_send();
		logic ack;
		logic [7:0] got;
		ssi_i2c_master_model_inst.start_cond();
		ssi_i2c_master_model_inst.put_byte(8'h51, ack);
		check("read address ack", ack, 1'b0);
		check("clock held", scl_oe_n, 1'b0);
		rd_chk("read status", `SSI_IDX_STATUS, 8'h05, 8'h05);
		rd_chk("read address", `SSI_IDX_BUF, 8'hff, 8'h51);
		wr(`SSI_IDX_BUF, 8'h9a);
		wr(`SSI_IDX_CTRL, 8'h36);
		ssi_i2c_master_model_inst.get_byte(1'b1, got);
		check("sent byte", got, 8'h9a);
		rd_chk("sent flag", `SSI_IDX_FLAGS, 8'h08, 8'h08);
		ssi_i2c_master_model_inst.stop_cond();
	endtask : slave_send
	// Ten-bit addressing: header byte, then low byte, each acknowledged and buffered.
	task automatic ten_bit();
		logic ack;
		wr(`SSI_IDX_OWNADDR, 8'hf0);
		wr(`SSI_IDX_CTRL, 8'h27);
		ssi_i2c_master_model_inst.start_cond();
		ssi_i2c_master_model_inst.put_byte(8'hf0, ack);
		check("header ack", ack, 1'b0);
		rd_chk("update flag", `SSI_IDX_STATUS, 8'h03, 8'h03);
		wr(`SSI_IDX_OWNADDR, 8'h3a);
		rd_chk("update cleared", `SSI_IDX_STATUS, 8'h02, 8'h00);
		rd_chk("header byte", `SSI_IDX_BUF, 8'hff, 8'hf0);
		ssi_i2c_master_model_inst.put_byte(8'h3a, ack);
		check("low byte ack", ack, 1'b0);
		rd_chk("low byte", `SSI_IDX_BUF, 8'hff, 8'h3a);
		ssi_i2c_master_model_inst.stop_cond();
		rd_chk("ten flag", `SSI_IDX_FLAGS, 8'h08, 8'h08);
		wr(`SSI_IDX_OWNADDR, 8'h50);
		wr(`SSI_IDX_CTRL, 8'h26);
	endtask : ten_bit
	// Each I2C mode code: start and stop flag only in the modes with bit 3 set, master mode included; master mode ignores addresses.
	task automatic mode_codes();
		logic ack;
		logic [3:0] codes [5] = '{4'h6, 4'h7, 4'hb, 4'he, 4'hf};
		foreach (codes[i]) begin
			wr(`SSI_IDX_CTRL, 8'h00);
			wr(`SSI_IDX_CTRL, {4'h2, codes[i]});
			rd_chk("flags drained", `SSI_IDX_FLAGS, 8'h08, 8'h00);
			ssi_i2c_master_model_inst.start_cond();
			if (codes[i] == `SSI_MODE_FWM) begin
				ssi_i2c_master_model_inst.put_byte(8'h50, ack);
				check("idle slave nack", ack, 1'b1);
			end
			ssi_i2c_master_model_inst.stop_cond();
			rd_chk("mode flag", `SSI_IDX_FLAGS, 8'h08, {4'h0, codes[i][3], 3'h0});
		end
	endtask : mode_codes
	// Chip-select mode: a high select forces the data-out direction bit set.
	task automatic spi_select();
		wr(`SSI_IDX_CTRL, 8'h00);
		wr(`SSI_IDX_CTRL, 8'h24);
		wr(`SSI_IDX_DIR, 8'hfb);
		cs_pin <= 1'b1;
		repeat (4) @(posedge clk);
		check("out dir forced", port_dir[2], 1'b1);
		rd_chk("dir read high", `SSI_IDX_DIR, 8'h04, 8'h04);
		cs_pin <= 1'b0;
		repeat (4) @(posedge clk);
		rd_chk("dir read low", `SSI_IDX_DIR, 8'h04, 8'h00);
		wr(`SSI_IDX_DIR, 8'hff);
	endtask : spi_select
	// No pin drive while disabled or with the bus pins set as outputs.
	task automatic pins_gated();
		logic ack;
		wr(`SSI_IDX_CTRL, 8'h06);
		ssi_i2c_master_model_inst.start_cond();
		rd_chk("disabled status", `SSI_IDX_STATUS, 8'h18, 8'h00);
		ssi_i2c_master_model_inst.put_byte(8'h50, ack);
		check("disabled nack", ack, 1'b1);
		ssi_i2c_master_model_inst.stop_cond();
		wr(`SSI_IDX_CTRL, 8'h26);
		wr(`SSI_IDX_DIR, 8'hed);
		ssi_i2c_master_model_inst.start_cond();
		ssi_i2c_master_model_inst.put_byte(8'h50, ack);
		check("outputs nack", ack, 1'b1);
		ssi_i2c_master_model_inst.stop_cond();
	endtask : pins_gated
	// Main sequence: reset for 20 cycles, then the scenarios in turn.
	initial begin
		reset = 1'b1;
		address = 10'h000;
		read = 1'b0;
		write = 1'b0;
		byteenable = 4'h0;
		writedata = 32'h00000000;
		cs_pin = 1'b0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		reset_values();
		addr_receive();
		addr_mismatch();
		slave_send();
		ten_bit();
		mode_codes();
		spi_select();
		pins_gated();
		end_of_test();
	end
	// Cuts a hang short and counts it as a mismatch.
	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		end_of_test();
	end
endmodule : tb_top
